/* File: logic/psc_map.vh */
// Purpose: timing constants for the pseudo-static ram port controller
// Assumes: 100 MHz clock, 10 ns period
// Notes:   least times round up to whole cycles, never below one
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_CLK_NS        10
`define PSC_WAKE_US       200
`define PSC_WAKE_CYC      ((`PSC_WAKE_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS + 1)
`define PSC_RC_NS         70
`define PSC_RC_CYC        ((`PSC_RC_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_SYNC_CYC      2
`define PSC_OE_NS         20
`define PSC_OE_CYC        ((`PSC_OE_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_WP_NS         60
`define PSC_WP_CYC        ((`PSC_WP_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_DW_NS         30
`define PSC_DW_CYC        ((`PSC_DW_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_OW_NS         5
`define PSC_OW_CYC        ((`PSC_OW_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_HZ_NS         10
`define PSC_HZ_CYC        ((`PSC_HZ_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_WC_NS         70
`define PSC_WC_CYC        ((`PSC_WC_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`endif

/* File: logic/psc_timer.v */
// Purpose: down counter used for every wait of the controller
// Assumes: load and count share one clock
// Notes:   done is high while the count stands at zero
`timescale 1ns/1ps
module psc_timer (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // control
  input  wire        load,
  input  wire [15:0] value,
  // status
  output wire        done
);
  reg [15:0] count; // remaining cycles

  // load wins over counting
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else if (load) begin
      count <= value;
    end else if (count != 16'h0000) begin
      count <= count - 16'h0001;
    end
  end

  assign done = (count == 16'h0000);
endmodule

/* File: logic/psc_ctrl.v */
// Purpose: host-side controller driving an asynchronous pseudo-static ram port
// Assumes: one 100 MHz clock; ram data pins sampled through two flip-flops
// Notes:   deep power-down loses memory contents; wake waits are enforced
`timescale 1ns/1ps
`include "psc_map.vh"

// Summary of operation
// RQ1: hold mode pin high, wait 200 us
// RQ2: mode pin low enters deep power-down
// RQ3: contents invalid after deep power-down
// RQ4: raise mode pin, wait 200 us again
// RQ5: read: write strobe high, output strobe low
// RQ6: select high is standby, low active
// RQ7: select held 60 ns before write end
// RQ8: address held 60 ns before write end
// RQ9: byte enables held 60 ns before end
// RQ10: data valid 30 ns before write end
// RQ11: read data valid 20 ns after strobe
// RQ12: device releases bus on write strobe
// RQ13: device drives again 5 ns after write
// RQ14: deselect releases bus within 10 ns
// RQ15: store only during select, strobe, enable
// RQ16: lower enable low byte, upper high byte
// RQ17: address never changes mid write
module psc_ctrl (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // user request side
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [19:0] req_addr,
  input  wire [15:0] req_wdata,
  input  wire [1:0]  req_byte_en,
  input  wire        sleep_req,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  output reg         contents_lost,
  output reg         powered_down,
  // ram pins
  output reg  [19:0] ram_addr,
  output reg         ram_select_n,
  output reg         power_mode_select,
  output reg         write_strobe_n,
  output reg         output_strobe_n,
  output reg         upper_byte_enable_n,
  output reg         lower_byte_enable_n,
  input  wire [15:0] ram_data_in,
  output reg  [15:0] ram_data_out,
  output reg         ram_data_oe
);
  // state codes
  localparam ST_WAKE  = 3'd0;  // post power-up / exit wait
  localparam ST_IDLE  = 3'd1;  // standby, ready for requests
  localparam ST_RD    = 3'd2;  // read strobes active
  localparam ST_WR    = 3'd3;  // write strobe active
  localparam ST_REC   = 3'd4;  // recovery after cycle end
  localparam ST_DPD   = 3'd5;  // deep power-down

  reg  [2:0]  state;          // current state
  reg  [15:0] sync1;          // first stage of data sampling
  reg  [15:0] sync2;          // second stage, read by logic
  reg         write_end;      // last access was a write
  reg         t_load;         // timer reload pulse
  reg  [15:0] t_value;        // timer reload value
  wire        t_done;         // timer has run out

  // cycle counts at full width, then cut to the timer width on purpose
  localparam [31:0] WAKE_FULL = `PSC_WAKE_CYC;
  localparam [31:0] RD_FULL   = `PSC_RC_CYC + `PSC_SYNC_CYC; // read hold plus sampler delay
  localparam [31:0] WP_FULL   = `PSC_WP_CYC;
  localparam [31:0] OW_FULL   = `PSC_OW_CYC;
  localparam [31:0] HZ_FULL   = `PSC_HZ_CYC;
  localparam [15:0] WAKE_CYC  = WAKE_FULL[15:0];
  localparam [15:0] RD_CYC    = RD_FULL[15:0];
  localparam [15:0] WP_CYC    = WP_FULL[15:0];
  localparam [15:0] OW_CYC    = OW_FULL[15:0];
  localparam [15:0] HZ_CYC    = HZ_FULL[15:0];

  // byte enable decode, shared by reads and writes
  function [1:0] lane_enables_n;
    input [1:0] en;
    begin
      lane_enables_n = ~en; // RQ16
    end
  endfunction

  // wait timer
  psc_timer u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .load  (t_load),
    .value (t_value),
    .done  (t_done)
  );

  // two-stage sampling of the ram data pins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
    end else begin
      sync1 <= ram_data_in;
      sync2 <= sync1;
    end
  end

  // main sequencer
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state               <= ST_WAKE;
      t_load              <= 1'b1;
      t_value             <= WAKE_CYC;
      req_ready           <= 1'b0;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= 16'h0000;
      contents_lost       <= 1'b0;
      powered_down        <= 1'b0;
      ram_addr            <= 20'h00000;
      ram_select_n        <= 1'b1;
      power_mode_select   <= 1'b1;
      write_strobe_n      <= 1'b1;
      output_strobe_n     <= 1'b1;
      upper_byte_enable_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
      ram_data_out        <= 16'h0000;
      ram_data_oe         <= 1'b0;
      write_end           <= 1'b0;
    end else begin
      t_load    <= 1'b0;
      rsp_valid <= 1'b0;
      case (state)
        // mode pin high, no access until wait ends
        ST_WAKE: begin
          power_mode_select <= 1'b1; // RQ1 RQ4
          ram_select_n      <= 1'b1;
          if (t_done && !t_load) begin
            state     <= ST_IDLE;
            req_ready <= 1'b1;
          end
        end
        // standby; accept one request or sleep
        ST_IDLE: begin
          ram_select_n <= 1'b1; // RQ6
          if (sleep_req) begin
            req_ready         <= 1'b0;
            power_mode_select <= 1'b0; // RQ2
            powered_down      <= 1'b1;
            contents_lost     <= 1'b1; // RQ3
            state             <= ST_DPD;
          end else if (req_valid && req_byte_en != 2'b00) begin
            req_ready    <= 1'b0;
            ram_addr     <= req_addr;
            ram_select_n <= 1'b0; // RQ6
            {upper_byte_enable_n, lower_byte_enable_n} <= lane_enables_n(req_byte_en);
            t_load       <= 1'b1;
            write_end    <= req_write;
            if (req_write) begin
              write_strobe_n <= 1'b0; // RQ15
              ram_data_out   <= req_wdata; // RQ10
              ram_data_oe    <= 1'b1; // RQ12
              t_value        <= WP_CYC; // RQ7 RQ8 RQ9
              state          <= ST_WR;
            end else begin
              output_strobe_n <= 1'b0; // RQ5
              t_value         <= RD_CYC; // RQ11
              state           <= ST_RD;
            end
          end
        end
        // address and enables steady until data sampled
        ST_RD: begin
          if (t_done && !t_load) begin
            rsp_rdata           <= sync2;
            rsp_valid           <= 1'b1;
            output_strobe_n     <= 1'b1;
            ram_select_n        <= 1'b1; // RQ14
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            t_load              <= 1'b1;
            t_value             <= HZ_CYC;
            state               <= ST_REC;
          end
        end
        // address, select, enables, data all steady
        ST_WR: begin
          if (t_done && !t_load) begin
            write_strobe_n      <= 1'b1; // RQ17
            ram_select_n        <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            rsp_valid           <= 1'b1;
            t_load              <= 1'b1;
            t_value             <= OW_CYC; // RQ13
            state               <= ST_REC;
          end
        end
        // bus released, then ready again
        ST_REC: begin
          ram_data_oe <= 1'b0;
          if (t_done && !t_load) begin
            state     <= ST_IDLE;
            req_ready <= 1'b1;
          end
        end
        // stay down while sleep requested
        ST_DPD: begin
          if (!sleep_req) begin
            power_mode_select <= 1'b1; // RQ4
            powered_down      <= 1'b0;
            t_load            <= 1'b1;
            t_value           <= WAKE_CYC;
            state             <= ST_WAKE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // contents_lost clears on first accepted write after wake
      if (state == ST_IDLE && req_valid && req_write && !sleep_req
          && req_byte_en != 2'b00) begin
        contents_lost <= 1'b0;
      end
    end
  end
endmodule

/* File: dv/psc_ram_model.sv */
// Purpose: behavioural pseudo-static ram facing the controller
// Assumes: 16 words decoded from the low address bits
// Notes: deep power-down inverts every word so lost data shows
`timescale 1ns/1ps
module psc_ram_model (
  // ram pins
  input  wire [19:0] addr,
  input  wire        sel_n,
  input  wire        pm,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire        ub_n,
  input  wire        lb_n,
  input  wire [15:0] bus,
  // data lanes toward the bus
  output wire [15:0] q
);
  reg  [15:0] mem [0:15];     // storage cells
  reg  [15:0] last = 16'h0000; // last read word
  integer     i;
  wire        act = !sel_n && pm;
  wire        rd = act && we_n && !oe_n && !(ub_n && lb_n);
  wire        rd_late;
  assign #20 rd_late = rd;
  wire        drv = rd && rd_late; // release at once
  wire [15:0] w = mem[addr[3:0]];
  // undriven lanes show the inverse of the last word
  assign q = {(ub_n || !drv) ? ~last[15:8] : w[15:8],
              (lb_n || !drv) ? ~last[7:0] : w[7:0]};
  always @(posedge rd) last = w;
  // store during the overlap only
  always @* begin
    if (act && !we_n) begin
      if (!lb_n) mem[addr[3:0]][7:0] = bus[7:0];
      if (!ub_n) mem[addr[3:0]][15:8] = bus[15:8];
    end
  end
  // refresh halts, contents decay
  always @(negedge pm) for (i = 0; i < 16; i = i + 1) mem[i] = ~mem[i];
endmodule

/* File: dv/psc_ctrl_asserts.sv */
// Purpose: port checks of the ram controller
// Assumes: one clock, async low reset
// Notes: bound to every controller instance
`timescale 1ns/1ps
module psc_ctrl_asserts (
  input wire clock, rst_n, req_ready, rsp_valid, contents_lost, ram_select_n,
  input wire power_mode_select, write_strobe_n, output_strobe_n, ram_data_oe,
  input wire upper_byte_enable_n, lower_byte_enable_n,
  input wire [19:0] ram_addr,
  input wire [15:0] ram_data_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire wr = !ram_select_n && !write_strobe_n; // write overlap
  a_sleep_idle: assert property (!power_mode_select |->
    ram_select_n && !req_ready && contents_lost) else $error("busy in sleep");
  a_read_strobes: assert property (!output_strobe_n |->
    write_strobe_n && !ram_select_n) else $error("bad read strobes");
  a_select_hold: assert property ($rose(write_strobe_n) |->
    $past(!ram_select_n, 6)) else $error("select too short");
  a_addr_stable: assert property (wr && $past(wr) |-> $stable(ram_addr))
    else $error("address moved");
  a_enable_hold: assert property ($rose(write_strobe_n) |->
    $past(!lower_byte_enable_n || !upper_byte_enable_n, 6)) else $error("enable short");
  a_data_stable: assert property (!write_strobe_n ##1 !write_strobe_n |->
    ram_data_oe && $stable(ram_data_out)) else $error("write data moved");
  a_no_clash: assert property (!output_strobe_n |-> !ram_data_oe)
    else $error("bus clash");
  a_write_done: assert property ($rose(write_strobe_n) |-> rsp_valid)
    else $error("no write response");
  c_write: cover property ($rose(write_strobe_n));
  c_read: cover property ($rose(output_strobe_n));
  c_sleep: cover property ($fell(power_mode_select));
endmodule
bind psc_ctrl psc_ctrl_asserts psc_ctrl_asserts_inst (.clock, .rst_n, .req_ready,
  .rsp_valid, .contents_lost, .ram_select_n, .power_mode_select, .write_strobe_n,
  .output_strobe_n, .ram_data_oe, .upper_byte_enable_n, .lower_byte_enable_n,
  .ram_addr, .ram_data_out);

/* File: dv/psc_ctrl_tb_top.sv */
// Purpose: self-checking bench of the ram controller
// Assumes: 100 MHz clock, inputs moved on falling edges
// Notes: two full wake waits keep the run near 40k cycles
`timescale 1ns/1ps
module psc_ctrl_tb_top;
  reg         clock = 0, rst_n = 0, req_valid = 0, req_write = 0, sleep_req = 0;
  reg  [19:0] req_addr = 0;
  reg  [15:0] req_wdata = 0, rd;
  reg  [1:0]  req_byte_en = 0;
  integer     num_errors = 0, checks_done = 0;
  wire        req_ready, rsp_valid, lost, pdn, sel_n, pm, we_n, oe_n, ub_n, lb_n, d_oe;
  wire [15:0] rsp_rdata, d_out, q;
  wire [19:0] ram_addr;
  wire [15:0] bus = d_oe ? d_out : q; // resolved data wires
  psc_ctrl psc_ctrl_inst (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_byte_en(req_byte_en), .sleep_req(sleep_req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .contents_lost(lost),
    .powered_down(pdn), .ram_addr(ram_addr), .ram_select_n(sel_n),
    .power_mode_select(pm), .write_strobe_n(we_n), .output_strobe_n(oe_n),
    .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n), .ram_data_in(bus),
    .ram_data_out(d_out), .ram_data_oe(d_oe));
  psc_ram_model psc_ram_model_inst (.addr(ram_addr), .sel_n(sel_n), .pm(pm),
    .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .bus(bus), .q(q));
  initial forever #5 clock = ~clock;
  task wrap_up;
    begin
      if (num_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input [63:0] what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("FAIL %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // wait n cycles, then up to 200 more for ready
  task to_ready(input integer n);
    integer k;
    begin
      repeat (n) @(negedge clock);
      for (k = 0; k < 200 && req_ready !== 1'b1; k = k + 1) @(negedge clock);
      if (k == 200) begin num_errors = num_errors + 1; wrap_up; end
    end
  endtask
  task access(input w, input [19:0] a, input [15:0] d, input [1:0] be);
    integer k;
    begin
      to_ready(0);
      {req_valid, req_write, req_addr, req_wdata, req_byte_en} = {1'b1, w, a, d, be};
      @(negedge clock);
      req_valid = 0;
      for (k = 0; k < 30 && rsp_valid !== 1'b1; k = k + 1) @(negedge clock);
      if (k == 30) begin num_errors = num_errors + 1; wrap_up; end
      rd = rsp_rdata;
    end
  endtask
  task sc_wake;
    begin
      repeat (20) @(negedge clock);
      chk({pm, sel_n, we_n, oe_n, req_ready}, 5'h1e, "reset");
      rst_n = 1;
      repeat (20000) @(negedge clock);
      chk({pm, req_ready}, 2'h2, "early");
      to_ready(0);
    end
  endtask
  task sc_lanes;
    begin
      access(1, 20'h00005, 16'h1234, 2'h3);
      access(1, 20'h00005, 16'hffcd, 2'h1);
      access(0, 20'h00005, 16'h0000, 2'h3);
      chk(rd, 16'h12cd, "lanes");
      access(1, 20'h00005, 16'hab00, 2'h2);
      access(0, 20'h00005, 16'h0000, 2'h3);
      chk(rd, 16'habcd, "upper");
      to_ready(0);
      {req_valid, req_byte_en} = 3'h4;
      repeat (3) @(negedge clock);
      chk({sel_n, req_ready}, 2'h3, "no_lanes");
      req_valid = 0;
      @(negedge clock);
    end
  endtask
  task sc_sleep;
    begin
      access(1, 20'h00007, 16'h0f0f, 2'h3);
      to_ready(0);
      sleep_req = 1;
      {req_valid, req_byte_en} = 3'h7;
      repeat (3) @(negedge clock);
      chk({pm, pdn, lost, sel_n}, 4'h7, "sleep");
      {sleep_req, req_valid} = 0;
      repeat (20000) @(negedge clock);
      chk({pm, req_ready}, 2'h2, "rewake");
      access(0, 20'h00007, 16'h0000, 2'h3);
      chk(rd, 16'hf0f0, "decay");
      access(1, 20'h00007, 16'h0000, 2'h3);
      chk(lost, 0, "relearn");
    end
  endtask
  initial begin
    sc_wake;
    sc_lanes;
    sc_sleep;
    wrap_up;
  end
endmodule
